// ==== pkg/rtfl_pkg.sv ====
package rtfl_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DIRECT_TEST = 6'h1A;
    localparam logic [5:0] IDX_TEST_MODE = 6'h1B;
    localparam logic [5:0] IDX_FIFO_STATUS = 6'h1C;
    localparam logic [5:0] IDX_TX_HIGH_MID = 6'h1D;
    localparam logic [5:0] IDX_TX_LOW_PART = 6'h1E;
    localparam logic [7:0] REG_RESET = 8'h00;
    // direct_path_test_control bits
    localparam int TC_SUBC_IN = 7;
    localparam int TC_SUBC_OUT = 6;
    localparam int TC_DIRECT = 5;
    localparam int TC_STAGE_SEL = 4;
    localparam int TC_SECOND_STAGE_GAIN_HALVE = 3;
    localparam int TC_FIRST_STAGE_GAIN_HALVE = 2;
    localparam int TC_FOLLOW = 1;
    localparam int TC_AGC_VIEW = 0;
    // test_mode_control bits
    localparam int TM_RF_LEVEL = 7;
    localparam int TM_IO1 = 3;
    localparam int TM_IO0 = 2;
    localparam int TM_DEC = 1;
    localparam int TM_FAST = 0;
    localparam logic [7:0] TM_STOP_MASK = 8'h0E;
    localparam logic [7:0] TM_WR_MASK = 8'h8F;
    // fifo_level_status bits
    localparam int FS_RSV = 7;
    localparam int FS_HIGH = 6;
    localparam int FS_LOW = 5;
    localparam int FS_OVF = 4;
    localparam logic [3:0] FIFO_HIGH_LVL = 4'h9;
    localparam logic [3:0] FIFO_LOW_LVL = 4'h3;
    localparam logic [3:0] FIFO_IRQ_ABOVE = 4'h8;
    localparam logic [3:0] FIFO_IRQ_BELOW = 4'h4;
    localparam logic [3:0] FIFO_ONE = 4'h1;
    // tx_count_low_partial layout
    localparam int TL_NIB_LSB = 4;
    localparam int TL_BITS_LSB = 1;
    localparam int TL_BROKEN = 0;
    // coder clock: 250 MHz system clock, 13.56 MHz carrier
    localparam int CLK_KHZ = 250000;
    localparam int RF_KHZ = 13560;
    localparam int FAST_DIV = CLK_KHZ / RF_KHZ;
    localparam int CODER_PRESCALE = 16;
endpackage : rtfl_pkg

// ==== logic/rtfl_regs.sv ====
// Function
// - both test registers clear at reset and while enable is low
// - subcarrier-input bit routes keying input pin into receive decoder
// - subcarrier-output bit drives receiver subcarrier on transmit keying pin
// - direct bit keys transmit from input pin unless subcarrier-output bit is set, and holds receiver reset
// - stage-select bit picks first or second amplifier stage output
// - bit 3 halves second stage gain and high-pass corner
// - bit 2 halves first stage gain and high-pass corner
// - gain-view bit shows automatic gain level on main strength bits
// - decoder or io test bits enter test mode; stop condition clears them unless a test mode write lands in the same cycle
// - fast coder bit clocks coders at full carrier rate
// - status bit 7 always reads zero
// - fifo high flag set during receive at nine bytes held
// - fifo low flag set during transmit at three bytes left
// - overflow flag set when host overfills the fifo
// - status low nibble reads held byte count minus one, zero when empty
// - status carries count nibble; broken-byte info sits in length reg
// - host writes count bits 11..4 into first length register
// - second length register holds low nibble, broken flag, bit count
// - length registers clear at reset, enable low, and transmit end
// - fifo level event: above eight in receive, below four in transmit
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
module rtfl_regs #(
    parameter int FIFO_CNT_W = 4,
    parameter int RSSI_W = 3,
    parameter int CODER_PRESCALE = rtfl_pkg::CODER_PRESCALE
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // chip control
    input wire logic chip_enable,
    input wire logic stop_condition,
    // pins and receive path
    input wire logic keying_input_pin,
    input wire logic rx_digital,
    input wire logic rx_subcarrier,
    input wire logic encoder_mod,
    output logic decoder_input,
    output logic tx_keying_pin,
    output logic rx_reset,
    // analog controls
    output logic stage_select,
    output logic first_stage_gain_halve,
    output logic second_stage_gain_halve,
    output logic follower_test,
    output logic rf_level_test,
    input wire logic [RSSI_W-1:0] rssi_main,
    input wire logic [RSSI_W-1:0] agc_level,
    output logic [RSSI_W-1:0] rssi_view,
    // test mode and coder clock
    output logic test_mode,
    output logic coder_tick,
    // fifo state
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic [FIFO_CNT_W-1:0] fifo_count,
    input wire logic fifo_overrun,
    output logic fifo_level_event,
    // transmit length
    input wire logic tx_eof,
    input wire logic tx_byte_done,
    input wire logic tx_partial_done,
    output logic [11:0] tx_byte_count,
    output logic tx_broken_byte,
    output logic [2:0] tx_broken_bits,
    output logic tx_data_end
);
    import rtfl_pkg::*;

    localparam int FAST_DIV_I = (FAST_DIV < 1) ? 1 : FAST_DIV;
    localparam int SLOW_DIV_I = FAST_DIV_I * CODER_PRESCALE;
    localparam logic [15:0] FAST_LAST = 16'(FAST_DIV_I - 1);
    localparam logic [15:0] SLOW_LAST = 16'(SLOW_DIV_I - 1);

    logic [7:0] test_ctrl_r;
    logic [7:0] test_mode_r;
    logic [7:0] tx_high_r;
    logic [7:0] tx_low_r;
    logic fifo_high_r;
    logic fifo_low_r;
    logic overflow_r;
    logic [3:0] fifo_nib_r;
    logic fifo_event_r;
    logic [7:0] status_word;
    logic wr_pend_r;
    logic [5:0] wr_idx_r;
    logic [31:0] rdata_nxt;
    logic [31:0] hrdata_r;
    logic addr_ok;
    logic [5:0] addr_idx;
    logic status_read;
    logic [15:0] div_cnt_r;
    logic [15:0] div_last;
    logic coder_tick_r;
    logic [11:0] sent_cnt_r;
    logic partial_sent_r;
    logic tx_end_r;
    logic decoder_input_r;
    logic tx_keying_r;
    logic [RSSI_W-1:0] rssi_view_r;
    logic wr_test_ctrl;
    logic wr_test_mode;
    logic wr_tx_high;
    logic wr_tx_low;
    logic [7:0] wbyte;

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign addr_ok = hsel && htrans[1] && hready;
    assign addr_idx = haddr[7:2];
    assign status_read = addr_ok && !hwrite && (addr_idx == IDX_FIFO_STATUS);
    assign wbyte = hwdata[7:0];
    assign wr_test_ctrl = wr_pend_r && (wr_idx_r == IDX_DIRECT_TEST);
    assign wr_test_mode = wr_pend_r && (wr_idx_r == IDX_TEST_MODE);
    assign wr_tx_high = wr_pend_r && (wr_idx_r == IDX_TX_HIGH_MID);
    assign wr_tx_low = wr_pend_r && (wr_idx_r == IDX_TX_LOW_PART);

    // write data arrives one cycle after its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 6'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite;
            wr_idx_r <= addr_idx;
        end
    end

    // reserved bit forced low; broken-byte data lives in the length register
    assign status_word = {1'b0, fifo_high_r, fifo_low_r, overflow_r, fifo_nib_r};

    // read data sampled in the address phase; unmapped reads return zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (addr_idx)
            IDX_DIRECT_TEST: rdata_nxt[7:0] = test_ctrl_r;
            IDX_TEST_MODE: rdata_nxt[7:0] = test_mode_r;
            IDX_FIFO_STATUS: rdata_nxt[7:0] = status_word;
            IDX_TX_HIGH_MID: rdata_nxt[7:0] = tx_high_r;
            IDX_TX_LOW_PART: rdata_nxt[7:0] = tx_low_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_r <= rdata_nxt;
        end
    end

    // direct path test register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_ctrl_r <= REG_RESET;
        end else if (!chip_enable) begin
            test_ctrl_r <= REG_RESET;
        end else if (wr_test_ctrl) begin
            test_ctrl_r <= wbyte;
        end
    end

    // test mode register; a host write in the stop cycle is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_mode_r <= REG_RESET;
        end else if (!chip_enable) begin
            test_mode_r <= REG_RESET;
        end else if (wr_test_mode) begin
            test_mode_r <= wbyte & TM_WR_MASK;
        end else if (stop_condition) begin
            test_mode_r <= test_mode_r & ~TM_STOP_MASK;
        end
    end

    assign test_mode = test_mode_r[TM_DEC] | test_mode_r[TM_IO1] | test_mode_r[TM_IO0];
    assign rf_level_test = test_mode_r[TM_RF_LEVEL];

    // analog controls straight from the register
    assign rx_reset = test_ctrl_r[TC_DIRECT];
    assign stage_select = test_ctrl_r[TC_STAGE_SEL];
    assign second_stage_gain_halve = test_ctrl_r[TC_SECOND_STAGE_GAIN_HALVE];
    assign first_stage_gain_halve = test_ctrl_r[TC_FIRST_STAGE_GAIN_HALVE];
    assign follower_test = test_ctrl_r[TC_FOLLOW];

    // pin routing, registered so the pins never glitch on a mux change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decoder_input_r <= 1'b0;
            tx_keying_r <= 1'b0;
            rssi_view_r <= '0;
        end else begin
            decoder_input_r <= test_ctrl_r[TC_SUBC_IN] ? keying_input_pin : rx_digital;
            if (test_ctrl_r[TC_SUBC_OUT]) begin
                tx_keying_r <= rx_subcarrier;
            end else if (test_ctrl_r[TC_DIRECT]) begin
                tx_keying_r <= keying_input_pin;
            end else begin
                tx_keying_r <= encoder_mod;
            end
            rssi_view_r <= test_ctrl_r[TC_AGC_VIEW] ? agc_level : rssi_main;
        end
    end

    assign decoder_input = decoder_input_r;
    assign tx_keying_pin = tx_keying_r;
    assign rssi_view = rssi_view_r;

    // coder clock enable; 13.56 MHz is not a divisor of 250 MHz, so
    // the fast rate is the nearest integer division
    assign div_last = test_mode_r[TM_FAST] ? FAST_LAST : SLOW_LAST;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= 16'h0000;
            coder_tick_r <= 1'b0;
        end else if (div_cnt_r >= div_last) begin
            div_cnt_r <= 16'h0000;
            coder_tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
            coder_tick_r <= 1'b0;
        end
    end

    assign coder_tick = coder_tick_r;

    // fifo status flags follow the level each cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_high_r <= 1'b0;
            fifo_low_r <= 1'b0;
            fifo_nib_r <= 4'h0;
            fifo_event_r <= 1'b0;
        end else begin
            fifo_high_r <= rx_active && (4'(fifo_count) >= FIFO_HIGH_LVL);
            fifo_low_r <= tx_active && (4'(fifo_count) <= FIFO_LOW_LVL);
            // empty reads as zero rather than wrapping
            fifo_nib_r <= (fifo_count == '0) ? 4'h0 : 4'(fifo_count) - FIFO_ONE;
            fifo_event_r <= (rx_active && (4'(fifo_count) > FIFO_IRQ_ABOVE))
                || (tx_active && (4'(fifo_count) < FIFO_IRQ_BELOW));
        end
    end

    assign fifo_level_event = fifo_event_r;

    // overflow is sticky; a status read clears it but a new overrun wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_r <= 1'b0;
        end else if (fifo_overrun) begin
            overflow_r <= 1'b1;
        end else if (!chip_enable || status_read) begin
            overflow_r <= 1'b0;
        end
    end

    // transmit length registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_high_r <= REG_RESET;
            tx_low_r <= REG_RESET;
        end else if (!chip_enable || tx_eof) begin
            tx_high_r <= REG_RESET;
            tx_low_r <= REG_RESET;
        end else begin
            if (wr_tx_high) begin
                tx_high_r <= wbyte;
            end
            if (wr_tx_low) begin
                tx_low_r <= wbyte;
            end
        end
    end

    assign tx_byte_count = {tx_high_r, tx_low_r[TL_NIB_LSB +: 4]};
    assign tx_broken_byte = tx_low_r[TL_BROKEN];
    assign tx_broken_bits = tx_low_r[TL_BITS_LSB +: 3];

    // bytes sent in the current frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sent_cnt_r <= 12'h000;
            partial_sent_r <= 1'b0;
        end else if (tx_eof || !chip_enable) begin
            sent_cnt_r <= 12'h000;
            partial_sent_r <= 1'b0;
        end else if (tx_active) begin
            if (tx_byte_done && (sent_cnt_r != tx_byte_count)) begin
                sent_cnt_r <= sent_cnt_r + 12'h001;
            end
            if (tx_partial_done) begin
                partial_sent_r <= 1'b1;
            end
        end
    end

    // data ends after all whole bytes and, if flagged, the broken byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_end_r <= 1'b0;
        end else begin
            tx_end_r <= tx_active && (sent_cnt_r == tx_byte_count)
                && (!tx_broken_byte || partial_sent_r);
        end
    end

    assign tx_data_end = tx_end_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    enable_clear_a: assert property (
        !chip_enable |=> (test_ctrl_r == REG_RESET) && (test_mode_r == REG_RESET))
        else $error("test registers not cleared by enable low");

    subc_in_route_a: assert property (
        test_ctrl_r[TC_SUBC_IN] |=> decoder_input == $past(keying_input_pin))
        else $error("decoder input not taken from keying pin");

    subc_out_route_a: assert property (
        test_ctrl_r[TC_SUBC_OUT] |=> tx_keying_pin == $past(rx_subcarrier))
        else $error("keying pin not driven by subcarrier");

    direct_mod_a: assert property (
        (test_ctrl_r[TC_DIRECT] && !test_ctrl_r[TC_SUBC_OUT])
        |-> rx_reset ##1 tx_keying_pin == $past(keying_input_pin))
        else $error("direct modulation path wrong");

    stage_sel_a: assert property (
        wr_test_ctrl && chip_enable |=> stage_select == $past(wbyte[TC_STAGE_SEL]))
        else $error("stage select does not follow write");

    gain_halve_a: assert property (
        wr_test_ctrl && chip_enable
        |=> {second_stage_gain_halve, first_stage_gain_halve} == $past(wbyte[TC_SECOND_STAGE_GAIN_HALVE:TC_FIRST_STAGE_GAIN_HALVE]))
        else $error("gain halving bits do not follow write");

    agc_view_a: assert property (
        test_ctrl_r[TC_AGC_VIEW] |=> rssi_view == $past(agc_level))
        else $error("gain level not shown on strength bits");

    stop_clear_a: assert property (
        stop_condition && !wr_test_mode |=> !test_mode)
        else $error("stop condition left test mode set");

    fast_tick_a: assert property (
        test_mode_r[TM_FAST] && coder_tick && !wr_test_mode |=> !coder_tick [*8])
        else $error("fast coder tick spacing wrong");

    status_rsv_a: assert property (
        addr_ok && !hwrite && addr_idx == IDX_FIFO_STATUS |=> hrdata[FS_RSV] == 1'b0)
        else $error("reserved status bit read as one");

    fifo_high_a: assert property (
        rx_active && 4'(fifo_count) >= FIFO_HIGH_LVL |=> status_word[FS_HIGH])
        else $error("fifo high flag missing");

    fifo_low_a: assert property (
        tx_active && 4'(fifo_count) <= FIFO_LOW_LVL |=> status_word[FS_LOW])
        else $error("fifo low flag missing");

    overflow_set_a: assert property (
        fifo_overrun |=> status_word[FS_OVF] [*1] ##1 (status_word[FS_OVF] || $past(status_read)
            || !$past(chip_enable) || $past(fifo_overrun)))
        else $error("overflow flag lost");

    count_nib_a: assert property (
        fifo_count == FIFO_CNT_W'(8) |=> status_word[3:0] == 4'h7)
        else $error("fifo count nibble is not count minus one");

    len_clear_a: assert property (
        tx_eof |=> tx_high_r == REG_RESET && tx_low_r == REG_RESET)
        else $error("length registers not cleared at frame end");

    level_evt_a: assert property (
        (rx_active && 4'(fifo_count) > FIFO_IRQ_ABOVE) |=> fifo_level_event)
        else $error("fifo level event missing");

    tx_end_a: assert property (
        tx_active && sent_cnt_r == tx_byte_count && !tx_broken_byte |=> tx_data_end)
        else $error("transmission did not end at byte count");

endmodule : rtfl_regs

// ==== tb/rtfl_host.sv ====
`timescale 1ns/100ps
module rtfl_host (
    // clock
    input wire logic hclk,
    // ahb-lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // read results and bus health
    output logic [7:0] rd_data,
    output int rd_count,
    output logic bus_fault
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_data = 8'h0;
        bus_fault = 1'b0;
    end

    // bounded wait, a stuck bus is flagged rather than hanging the run
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 64);
        if (hready !== 1'b1 || hresp !== 1'b0) bus_fault <= 1'b1;
    endtask : wait_ready

    // one single word transfer; called just after a rising edge
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] data);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, data};
        wait_ready();
        if (!wr) begin
            rd_data <= hrdata[7:0];
            rd_count <= rd_count + 1;
        end
    endtask : xfer
endmodule : rtfl_host

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import rtfl_pkg::*;
    typedef struct {string name; logic [7:0] val;} rtfl_exp_s;
    localparam int PRESC = 2;
    logic hclk, hresetn, chip_enable, stop_condition, hsel, hwrite, hresp, bus_fault;
    logic keying_input_pin, rx_digital, rx_subcarrier, encoder_mod;
    logic rx_active, tx_active, fifo_overrun, tx_eof, tx_byte_done, tx_partial_done;
    logic decoder_input, tx_keying_pin, rx_reset, stage_select, follower_test;
    logic first_stage_gain_halve, second_stage_gain_halve, rf_level_test, test_mode;
    logic coder_tick, fifo_level_event, tx_broken_byte, tx_data_end;
    logic [2:0] rssi_main, agc_level, rssi_view, hsize, tx_broken_bits;
    logic [3:0] fifo_count;
    logic [11:0] tx_byte_count;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [7:0] rd_data, v, x, s;
    wire hready;
    int rd_count, n_errors, total_checks, gap;
    rtfl_exp_s exp_q[$];
    rtfl_exp_s cur;

    rtfl_regs #(.CODER_PRESCALE(PRESC)) DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout(hready), .hresp, .hrdata, .chip_enable, .stop_condition,
        .keying_input_pin, .rx_digital, .rx_subcarrier, .encoder_mod, .decoder_input,
        .tx_keying_pin, .rx_reset, .stage_select, .first_stage_gain_halve,
        .second_stage_gain_halve, .follower_test, .rf_level_test, .rssi_main, .agc_level,
        .rssi_view, .test_mode, .coder_tick, .rx_active, .tx_active, .fifo_count,
        .fifo_overrun, .fifo_level_event, .tx_eof, .tx_byte_done, .tx_partial_done,
        .tx_byte_count, .tx_broken_byte, .tx_broken_bits, .tx_data_end
    );

    rtfl_host host (
        .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hresp,
        .hrdata, .rd_data, .rd_count, .bus_fault
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    // the read result is compared by the monitor below, in order
    task automatic rd(input logic [5:0] idx, input logic [7:0] val, input string nm);
        exp_q.push_back('{nm, val});
        host.xfer(1'b0, idx, 8'h00);
    endtask : rd

    // first loop skips to a tick, second measures the spacing
    task automatic tick_gap();
        repeat (2) begin
            gap = 0;
            do begin
                @(posedge hclk);
                gap++;
            end while (coder_tick !== 1'b1 && gap < 600);
        end
        if (gap >= 600) begin
            n_errors++;
            results();
        end
    endtask : tick_gap

    initial forever begin
        @(rd_count);
        if (exp_q.size() == 0) begin
            chk("unexpected_read", 32'h1, 32'h0);
        end else begin
            cur = exp_q.pop_front();
            chk(cur.name, {24'h0, rd_data}, {24'h0, cur.val});
        end
    end

    initial begin
        repeat (60000) @(posedge hclk);
        n_errors++;
        results();
    end

    initial begin
        {hresetn, stop_condition, keying_input_pin, rx_digital, rx_subcarrier} = 5'h0;
        {encoder_mod, rx_active, tx_active, fifo_overrun, tx_eof} = 5'h0;
        {tx_byte_done, tx_partial_done, fifo_count, rssi_main, agc_level} = 12'h0;
        chip_enable = 1'b1;
        void'($urandom(31820));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(IDX_DIRECT_TEST, REG_RESET, "direct_test");
        rd(IDX_TEST_MODE, REG_RESET, "test_mode_reg");
        rd(IDX_TX_HIGH_MID, REG_RESET, "tx_high_mid");
        rd(IDX_TX_LOW_PART, REG_RESET, "tx_low_part");
        rd(6'h00, 8'h00, "unmapped");
        // every routing combination, random low bits and pin levels
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            v[7:5] = 3'(i);
            {keying_input_pin, rx_digital, rx_subcarrier, encoder_mod} <= 4'($urandom);
            rssi_main <= 3'($urandom);
            agc_level <= 3'($urandom);
            host.xfer(1'b1, IDX_DIRECT_TEST, v);
            step(2);
            x = {7'h0, v[6] ? rx_subcarrier : (v[5] ? keying_input_pin : encoder_mod)};
            chk("decoder_input", 32'(decoder_input), 32'(v[7] ? keying_input_pin : rx_digital));
            chk("tx_keying_pin", 32'(tx_keying_pin), 32'(x));
            s = {3'h0, rx_reset, stage_select, second_stage_gain_halve, first_stage_gain_halve,
                follower_test};
            chk("analog_ctrl", 32'(s), 32'(v[5:1]));
            chk("rssi_view", 32'(rssi_view), 32'(v[0] ? agc_level : rssi_main));
            rd(IDX_DIRECT_TEST, v, "direct_test");
        end
        host.xfer(1'b1, IDX_TEST_MODE, 8'hFF);
        step(2);
        chk("test_mode", 32'({test_mode, rf_level_test}), 32'h3);
        tick_gap();
        chk("fast_gap", 32'(gap), 32'(FAST_DIV));
        rd(IDX_TEST_MODE, TM_WR_MASK, "test_mode_reg");
        stop_condition <= 1'b1;
        step(1);
        stop_condition <= 1'b0;
        step(2);
        chk("test_mode", 32'(test_mode), 32'h0);
        rd(IDX_TEST_MODE, TM_WR_MASK & ~TM_STOP_MASK, "test_mode_reg");
        host.xfer(1'b1, IDX_TEST_MODE, 8'h00);
        tick_gap();
        chk("slow_gap", 32'(gap), 32'(FAST_DIV * PRESC));
        // fill levels 0 to 12 with random direction flags
        for (int c = 0; c <= 12; c++) begin
            x = 8'($urandom);
            fifo_count <= 4'(c);
            rx_active <= x[0];
            tx_active <= x[1];
            step(2);
            s = {1'b0, x[0] && c >= 9, x[1] && c <= 3, 1'b0, 4'(c == 0 ? 0 : c - 1)};
            chk("level_event", 32'(fifo_level_event), 32'((x[0] && c > 8) || (x[1] && c < 4)));
            rd(IDX_FIFO_STATUS, s, "fifo_status");
        end
        fifo_count <= 4'h0;
        rx_active <= 1'b0;
        tx_active <= 1'b0;
        host.xfer(1'b1, IDX_FIFO_STATUS, 8'hFF);
        fifo_overrun <= 1'b1;
        step(1);
        fifo_overrun <= 1'b0;
        rd(IDX_FIFO_STATUS, 8'h10, "overflow");
        rd(IDX_FIFO_STATUS, 8'h00, "overflow_clear");
        host.xfer(1'b1, IDX_TX_HIGH_MID, 8'hAB);
        host.xfer(1'b1, IDX_TX_LOW_PART, 8'hC5);
        step(1);
        s = {tx_broken_byte, tx_broken_bits, 4'h0};
        chk("tx_count", 32'(tx_byte_count), 32'h0ABC);
        chk("tx_broken", 32'(s), 32'hA0);
        rd(IDX_TX_LOW_PART, 8'hC5, "tx_low_part");
        tx_eof <= 1'b1;
        step(1);
        tx_eof <= 1'b0;
        rd(IDX_TX_HIGH_MID, 8'h00, "tx_high_mid");
        rd(IDX_TX_LOW_PART, 8'h00, "tx_low_part");
        // two whole bytes plus one bit of a broken byte
        host.xfer(1'b1, IDX_TX_LOW_PART, 8'h23);
        tx_active <= 1'b1;
        step(2);
        chk("data_end", 32'(tx_data_end), 32'h0);
        repeat (2) begin
            tx_byte_done <= 1'b1;
            step(1);
            tx_byte_done <= 1'b0;
            step(1);
        end
        step(2);
        chk("data_end", 32'(tx_data_end), 32'h0);
        tx_partial_done <= 1'b1;
        step(1);
        tx_partial_done <= 1'b0;
        step(2);
        chk("data_end", 32'(tx_data_end), 32'h1);
        tx_active <= 1'b0;
        host.xfer(1'b1, IDX_DIRECT_TEST, 8'hFF);
        host.xfer(1'b1, IDX_TX_HIGH_MID, 8'h5A);
        chip_enable <= 1'b0;
        step(2);
        chip_enable <= 1'b1;
        rd(IDX_DIRECT_TEST, REG_RESET, "direct_test");
        rd(IDX_TX_HIGH_MID, REG_RESET, "tx_high_mid");
        step(3);
        chk("bus_fault", 32'(bus_fault), 32'h0);
        chk("pending_reads", 32'(exp_q.size()), 32'h0);
        results();
    end
endmodule : testbench
